// ==== design/qsc_consts.svh ====
// qsc_consts.svh: offsets, field positions, reset values and counts
// assumes: included by bare name after the package is compiled
`ifndef QSC_CONSTS_SVH
`define QSC_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define QSC_A_MCTL 8'h00
`define QSC_A_PCTL 8'h01
`define QSC_A_QCTL 8'h02
`define QSC_A_TSTAT 8'h03
`define QSC_A_CMD_HI 4'h1
`define QSC_A_DAT_HI 4'h2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define QSC_MC_MASTER_SELECT 15
`define QSC_MC_OD 14
`define QSC_MC_LEN_HI 13
`define QSC_MC_LEN_LO 10
`define QSC_MC_CLOCK_IDLE_LEVEL 9
`define QSC_MC_CLOCK_EDGE_PHASE 8
`define QSC_MC_BAUD_HI 7
`define QSC_MC_BAUD_LO 0
`define QSC_PC_EN 15
`define QSC_QC_FIE 15
`define QSC_QC_WRAPAROUND_ENABLE 14
`define QSC_QC_WRAP_TARGET 13
`define QSC_QC_END_HI 11
`define QSC_QC_END_LO 8
`define QSC_QC_NEW_HI 3
`define QSC_QC_NEW_LO 0
`define QSC_TS_LOOP 10
`define QSC_TS_HALT_FAULT_IRQ_ENABLE 9
`define QSC_TS_HALT 8
`define QSC_TS_FIN 7
`define QSC_TS_MODE_FAULT_FLAG 6
`define QSC_TS_HACK 5
`define QSC_CMD_LEN_EN 4
`define QSC_PIN_MISO 0
`define QSC_PIN_MOSI 1
`define QSC_PIN_SCK 2
`define QSC_PIN_SS 3
`define QSC_NPIN 7

// ----------------------------------------------------------------
// reset values, masks and counts
// ----------------------------------------------------------------
`define QSC_MCTL_RST 16'h0100
`define QSC_QCTL_RST 16'h0000
`define QSC_QCTL_MASK 16'hef0f
`define QSC_PCS_IDLE 4'hf
`define QSC_LEN_DEF 5'h08
`define QSC_LEN_MAX 5'h10
`define QSC_BAUD_MIN 8'h02

`endif

// ==== design/qsc_pkg.sv ====
// qsc_pkg: types shared by the serial port control files
// assumes: compiled before every other design file
package qsc_pkg;
  typedef logic [7:0] qsc_addr_t;
  typedef logic [15:0] qsc_data_t;
  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_SHIFT, S_DONE, S_HALT, S_SWAIT} qsc_state_t;
endpackage : qsc_pkg

// ==== design/qsc_sync.sv ====
// qsc_sync: two-flop synchroniser for pin inputs
// assumes: inputs are asynchronous to clock; q is read by the caller
`timescale 1ns/1ns
`default_nettype none
module qsc_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : qsc_sync
`default_nettype wire

// ==== design/qsc_baud.sv ====
// qsc_baud: modulus counter giving one tick per serial half period
// assumes: div is a register value on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "qsc_consts.svh"
module qsc_baud (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [7:0] div,
  output logic tick
);
  logic [7:0] cnt_ff;

  // tick every div cycles, none below the smallest divisor
  assign tick = run && (div >= `QSC_BAUD_MIN) && (cnt_ff == div - 8'h01);

  // count cycles of the system clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 8'h00;
    end else if (!run || tick) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  baud_off_a: assert property (@(posedge clock) disable iff (!rst_b)
    (div < `QSC_BAUD_MIN) |-> !tick) else $error("tick with divisor below two");
  baud_period_a: assert property (@(posedge clock) disable iff (!rst_b)
    (tick && div == 8'h02) ##1 (run && div == 8'h02) |-> !tick ##1 (tick || !run || div != 8'h02))
    else $error("divisor two does not tick every second cycle");
endmodule : qsc_baud
`default_nettype wire

// ==== design/qsc_top.sv ====
// qsc_top: queued serial port control, master or slave, with command queue
// assumes: plain register port on clock; serial pins asynchronous to clock
`timescale 1ns/1ns
`default_nettype none
`include "qsc_consts.svh"
module qsc_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire qsc_pkg::qsc_addr_t reg_addr,
  input wire qsc_pkg::qsc_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output qsc_pkg::qsc_data_t reg_rdata,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_b,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_b,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_b,
  input wire logic ss_pcs0_b_i,
  output logic ss_pcs0_b_o,
  output logic ss_pcs0_b_oe_b,
  output logic [2:0] pcs_o,
  output logic [2:0] pcs_oe_b,
  output logic irq_req
);
  import qsc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] mctl_ff;
  logic en_ff;
  logic en_d_ff;
  logic [6:0] dir_ff;
  logic [15:0] qbuf_ff;
  logic [15:0] qctl_ff;
  logic loop_ff;
  logic halt_fault_irq_enable_ff;
  logic halt_ff;
  logic fin_ff;
  logic mode_fault_flag_ff;
  logic hack_ff;
  logic [7:0] cmd_ff [16];
  logic [15:0] tx_ff [16];
  logic [15:0] rx_ff [16];
  qsc_state_t st_ff;
  logic [3:0] ptr_ff;
  logic [15:0] sh_ff;
  logic [15:0] rsh_ff;
  logic [4:0] nbits_ff;
  logic [5:0] hc_ff;
  logic [3:0] pcs_ff;
  logic sck_val_ff;
  logic sck_d_ff;
  logic [6:0] pin_o_ff;
  logic [6:0] pin_oe_b_ff;
  logic [15:0] rdata_ff;
  logic irq_ff;

  // ----------------------------------------------------------------
  // field views and decode
  // ----------------------------------------------------------------
  logic master;
  logic odsel;
  logic clock_idle_level;
  logic clock_edge_phase;
  logic [3:0] len_code;
  logic [7:0] baud;
  logic [3:0] q_end;
  logic [3:0] q_new;
  logic [3:0] pin_s;
  logic ss_s;
  logic tick;
  logic wr_mctl;
  logic wr_pctl;
  logic wr_qctl;
  logic wr_tstat;
  logic wr_cmd;
  logic wr_dat;
  logic edge_ev;
  logic lead;
  logic sample;
  logic last;
  logic rx_in;
  logic at_end;
  logic stop;
  logic [3:0] nxt_ptr;
  logic [4:0] nxt_nbits;
  logic [6:0] pin_val;
  logic [15:0] nxt_rdata;
  logic [7:0] cmd_cur;

  assign master = mctl_ff[`QSC_MC_MASTER_SELECT];
  assign odsel = mctl_ff[`QSC_MC_OD];
  assign clock_idle_level = mctl_ff[`QSC_MC_CLOCK_IDLE_LEVEL];
  assign clock_edge_phase = mctl_ff[`QSC_MC_CLOCK_EDGE_PHASE];
  assign len_code = mctl_ff[`QSC_MC_LEN_HI:`QSC_MC_LEN_LO];
  assign baud = mctl_ff[`QSC_MC_BAUD_HI:`QSC_MC_BAUD_LO];
  assign q_end = qctl_ff[`QSC_QC_END_HI:`QSC_QC_END_LO];
  assign q_new = qctl_ff[`QSC_QC_NEW_HI:`QSC_QC_NEW_LO];
  assign ss_s = pin_s[`QSC_PIN_SS];
  assign wr_mctl = reg_wr && (reg_addr == `QSC_A_MCTL);
  assign wr_pctl = reg_wr && (reg_addr == `QSC_A_PCTL);
  assign wr_qctl = reg_wr && (reg_addr == `QSC_A_QCTL);
  assign wr_tstat = reg_wr && (reg_addr == `QSC_A_TSTAT);
  assign wr_cmd = reg_wr && (reg_addr[7:4] == `QSC_A_CMD_HI);
  assign wr_dat = reg_wr && (reg_addr[7:4] == `QSC_A_DAT_HI);
  assign cmd_cur = cmd_ff[ptr_ff];

  // length code decode
  function automatic logic [4:0] len_dec(input logic [3:0] code);
    if (code == 4'h0) begin
      len_dec = `QSC_LEN_MAX;
    end else if (code[3]) begin
      len_dec = {1'b0, code};
    end else begin
      len_dec = `QSC_LEN_DEF;
    end
  endfunction : len_dec

  // ----------------------------------------------------------------
  // pin synchronisers and baud divider
  // ----------------------------------------------------------------
  qsc_sync #(.W(4)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .d({ss_pcs0_b_i, sck_i, mosi_i, miso_i}),
    .q(pin_s)
  );

  qsc_baud u_baud (
    .clock(clock),
    .rst_b(rst_b),
    .run(master && (st_ff == S_SHIFT)),
    .div(baud),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // serial edge classification
  // ----------------------------------------------------------------
  assign edge_ev = (st_ff == S_SHIFT) && (master ? tick : (pin_s[`QSC_PIN_SCK] != sck_d_ff));
  assign lead = master ? ~hc_ff[0] : (pin_s[`QSC_PIN_SCK] != clock_idle_level);
  assign sample = lead ^ clock_edge_phase;
  assign last = ((hc_ff + 6'h01) == {nbits_ff, 1'b0});
  assign rx_in = loop_ff ? sh_ff[15] : (master ? pin_s[`QSC_PIN_MISO] : pin_s[`QSC_PIN_MOSI]);
  assign nxt_nbits = (!master || cmd_cur[`QSC_CMD_LEN_EN]) ? len_dec(len_code) : `QSC_LEN_DEF;
  assign at_end = (ptr_ff == q_end);
  assign stop = at_end && !qctl_ff[`QSC_QC_WRAPAROUND_ENABLE];
  assign nxt_ptr = at_end ? (qctl_ff[`QSC_QC_WRAP_TARGET] ? q_new : 4'h0) : ptr_ff + 4'h1;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // mode, length, clock shape and divisor
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mctl_ff <= `QSC_MCTL_RST;
    end else if (wr_mctl) begin
      mctl_ff <= reg_wdata;
    end
  end

  // port enable and pin direction; engine ends a finished queue
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      en_ff <= 1'b0;
      dir_ff <= 7'h00;
      en_d_ff <= 1'b0;
    end else begin
      en_d_ff <= en_ff;
      if (wr_pctl) begin
        en_ff <= reg_wdata[`QSC_PC_EN];
        dir_ff <= reg_wdata[6:0];
      end else if ((st_ff == S_DONE) && stop) begin
        en_ff <= 1'b0;
      end
    end
  end

  // queue control: software fills the buffer, current copy taken between transfers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      qbuf_ff <= `QSC_QCTL_RST;
      qctl_ff <= `QSC_QCTL_RST;
    end else begin
      if (wr_qctl) begin
        qbuf_ff <= reg_wdata & `QSC_QCTL_MASK;
      end
      if ((st_ff == S_IDLE) || (st_ff == S_LOAD)) begin
        qctl_ff <= qbuf_ff;
      end
    end
  end

  // test bits and status flags; hardware set wins over write-one clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loop_ff <= 1'b0;
      halt_fault_irq_enable_ff <= 1'b0;
      halt_ff <= 1'b0;
      fin_ff <= 1'b0;
      mode_fault_flag_ff <= 1'b0;
      hack_ff <= 1'b0;
    end else begin
      if (wr_tstat) begin
        loop_ff <= reg_wdata[`QSC_TS_LOOP];
        halt_fault_irq_enable_ff <= reg_wdata[`QSC_TS_HALT_FAULT_IRQ_ENABLE];
        halt_ff <= reg_wdata[`QSC_TS_HALT];
      end
      if ((st_ff == S_DONE) && at_end) begin
        fin_ff <= 1'b1;
      end else if (wr_tstat && reg_wdata[`QSC_TS_FIN]) begin
        fin_ff <= 1'b0;
      end
      // only a select pin left as input can be pulled low by another master
      if (master && en_ff && !dir_ff[`QSC_PIN_SS] && !ss_s) begin
        mode_fault_flag_ff <= 1'b1;
      end else if (wr_tstat && reg_wdata[`QSC_TS_MODE_FAULT_FLAG]) begin
        mode_fault_flag_ff <= 1'b0;
      end
      if ((st_ff == S_DONE) && !stop && halt_ff) begin
        hack_ff <= 1'b1;
      end else if (wr_tstat && reg_wdata[`QSC_TS_HACK]) begin
        hack_ff <= 1'b0;
      end
    end
  end

  // command bytes and transmit words, written only from the register port
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) begin
        cmd_ff[i] <= 8'h00;
        tx_ff[i] <= 16'h0000;
      end
    end else begin
      if (wr_cmd) begin
        cmd_ff[reg_addr[3:0]] <= reg_wdata[7:0];
      end
      if (wr_dat) begin
        tx_ff[reg_addr[3:0]] <= reg_wdata;
      end
    end
  end

  // received words stored at the end of each transfer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) begin
        rx_ff[i] <= 16'h0000;
      end
    end else if (st_ff == S_DONE) begin
      rx_ff[ptr_ff] <= rsh_ff;
    end
  end

  // ----------------------------------------------------------------
  // queue sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= S_IDLE;
    end else begin
      case (st_ff)
        S_IDLE: begin
          if (en_ff && !halt_ff && (master || !ss_s)) begin
            st_ff <= S_LOAD;
          end
        end
        S_LOAD: begin
          st_ff <= S_SHIFT;
        end
        S_SHIFT: begin
          if (!en_ff || (!master && ss_s)) begin
            st_ff <= S_IDLE;
          end else if (edge_ev && last) begin
            st_ff <= S_DONE;
          end
        end
        S_DONE: begin
          if (stop) begin
            st_ff <= S_IDLE;
          end else if (halt_ff) begin
            st_ff <= S_HALT;
          end else if (master) begin
            st_ff <= S_LOAD;
          end else begin
            st_ff <= S_SWAIT;
          end
        end
        S_HALT: begin
          if (!en_ff) begin
            st_ff <= S_IDLE;
          end else if (!halt_ff) begin
            st_ff <= master ? S_LOAD : S_SWAIT;
          end
        end
        S_SWAIT: begin
          if (ss_s || !en_ff) begin
            st_ff <= S_IDLE;
          end
        end
        default: begin
          st_ff <= S_IDLE;
        end
      endcase
    end
  end

  // queue pointer: start pointer on enable, advance or wrap after each transfer that does not stop the queue
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ptr_ff <= 4'h0;
    end else if (en_ff && !en_d_ff) begin
      ptr_ff <= qbuf_ff[`QSC_QC_NEW_HI:`QSC_QC_NEW_LO];
    end else if ((st_ff == S_DONE) && !stop) begin
      ptr_ff <= nxt_ptr;
    end
  end

  // ----------------------------------------------------------------
  // data serializer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sh_ff <= 16'h0000;
      rsh_ff <= 16'h0000;
      nbits_ff <= `QSC_LEN_DEF;
      hc_ff <= 6'h00;
      pcs_ff <= `QSC_PCS_IDLE;
    end else if (st_ff == S_LOAD) begin
      sh_ff <= tx_ff[ptr_ff] << (`QSC_LEN_MAX - nxt_nbits);
      rsh_ff <= 16'h0000;
      nbits_ff <= nxt_nbits;
      hc_ff <= 6'h00;
      pcs_ff <= master ? cmd_cur[3:0] : `QSC_PCS_IDLE;
    end else if (edge_ev) begin
      hc_ff <= hc_ff + 6'h01;
      if (sample) begin
        rsh_ff <= {rsh_ff[14:0], rx_in};
      end else if (hc_ff != 6'h00) begin
        sh_ff <= {sh_ff[14:0], 1'b0};
      end
    end else if ((st_ff == S_IDLE) || (st_ff == S_SWAIT)) begin
      pcs_ff <= `QSC_PCS_IDLE;
    end
  end

  // serial clock: idle level outside a master transfer, toggles on each tick
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sck_val_ff <= 1'b0;
      sck_d_ff <= 1'b0;
    end else begin
      sck_d_ff <= pin_s[`QSC_PIN_SCK];
      if (st_ff != S_SHIFT) begin
        sck_val_ff <= clock_idle_level;
      end else if (master && tick) begin
        sck_val_ff <= ~sck_val_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  assign pin_val = {pcs_ff[3:1], pcs_ff[0], sck_val_ff, sh_ff[15], sh_ff[15]};

  // direction picks driven pins; open drain releases a driven one at high level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_o_ff <= 7'h00;
      pin_oe_b_ff <= 7'h7f;
    end else begin
      for (int i = 0; i < `QSC_NPIN; i++) begin
        pin_o_ff[i] <= odsel ? 1'b0 : pin_val[i];
        pin_oe_b_ff[i] <= !(dir_ff[i] && !(odsel && pin_val[i]));
      end
    end
  end

  assign miso_o = pin_o_ff[`QSC_PIN_MISO];
  assign miso_oe_b = pin_oe_b_ff[`QSC_PIN_MISO];
  assign mosi_o = pin_o_ff[`QSC_PIN_MOSI];
  assign mosi_oe_b = pin_oe_b_ff[`QSC_PIN_MOSI];
  assign sck_o = pin_o_ff[`QSC_PIN_SCK];
  assign sck_oe_b = pin_oe_b_ff[`QSC_PIN_SCK];
  assign ss_pcs0_b_o = pin_o_ff[`QSC_PIN_SS];
  assign ss_pcs0_b_oe_b = pin_oe_b_ff[`QSC_PIN_SS];
  assign pcs_o = pin_o_ff[6:4];
  assign pcs_oe_b = pin_oe_b_ff[6:4];

  // ----------------------------------------------------------------
  // register read and interrupt request
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_addr == `QSC_A_MCTL) begin
      nxt_rdata = mctl_ff;
    end else if (reg_addr == `QSC_A_PCTL) begin
      nxt_rdata = {en_ff, 8'h00, dir_ff};
    end else if (reg_addr == `QSC_A_QCTL) begin
      nxt_rdata = qctl_ff;
    end else if (reg_addr == `QSC_A_TSTAT) begin
      nxt_rdata = {5'h00, loop_ff, halt_fault_irq_enable_ff, halt_ff, fin_ff, mode_fault_flag_ff, hack_ff, 1'b0, ptr_ff};
    end else if (reg_addr[7:4] == `QSC_A_CMD_HI) begin
      nxt_rdata = {8'h00, cmd_ff[reg_addr[3:0]]};
    end else if (reg_addr[7:4] == `QSC_A_DAT_HI) begin
      nxt_rdata = rx_ff[reg_addr[3:0]];
    end
  end

  // read data for one cycle only; interrupt gated by enables
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 16'h0000;
      irq_ff <= 1'b0;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 16'h0000;
      irq_ff <= (fin_ff && qctl_ff[`QSC_QC_FIE]) || ((hack_ff || mode_fault_flag_ff) && halt_fault_irq_enable_ff);
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq_req = irq_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  fetch_master_a: assert property ((st_ff == S_LOAD && !master) |=> pcs_ff == `QSC_PCS_IDLE)
    else $error("slave transfer drove command selects");
  len_decode_a: assert property ((st_ff == S_LOAD && master && !cmd_cur[`QSC_CMD_LEN_EN]) |=>
    nbits_ff == `QSC_LEN_DEF) else $error("length enable clear did not give eight bits");
  len_zero_a: assert property ((st_ff == S_LOAD && !master && len_code == 4'h0) |=>
    nbits_ff == `QSC_LEN_MAX) else $error("length code zero not sixteen bits");
  idle_level_a: assert property ((st_ff == S_IDLE && $stable(clock_idle_level))[*2] |-> sck_val_ff == clock_idle_level)
    else $error("serial clock not at idle level");
  queue_buf_a: assert property ((st_ff == S_SHIFT) |=> $stable(qctl_ff))
    else $error("queue control changed during transfer");
  read_current_a: assert property ((reg_rd && reg_addr == `QSC_A_QCTL) |=> reg_rdata == $past(qctl_ff))
    else $error("queue control read not current value");
  irq_gate_a: assert property (##1 irq_req == $past((fin_ff && qctl_ff[`QSC_QC_FIE])
    || ((hack_ff || mode_fault_flag_ff) && halt_fault_irq_enable_ff))) else $error("interrupt request not gated by enables");
  wrap_target_a: assert property ((st_ff == S_DONE && at_end && qctl_ff[`QSC_QC_WRAPAROUND_ENABLE] && en_d_ff)
    |=> ptr_ff == ($past(qctl_ff[`QSC_QC_WRAP_TARGET]) ? $past(q_new) : 4'h0)) else $error("wrong wrap address");
  stop_end_a: assert property ((st_ff == S_DONE && stop && !wr_pctl) |=> !en_ff && fin_ff)
    else $error("queue did not stop at end");
  mode_fault_a: assert property ((master && en_ff && !dir_ff[`QSC_PIN_SS] && !ss_s) |=> mode_fault_flag_ff && master)
    else $error("mode fault not raised");
  fault_keep_a: assert property (($rose(mode_fault_flag_ff) && !$past(wr_pctl)) |-> $past(en_ff) == en_ff)
    else $error("mode fault changed the port enable");
  open_drain_a: assert property ((odsel && pin_val[`QSC_PIN_SCK]) |=> sck_oe_b)
    else $error("open drain pin drove a high level");

  wrap_c: cover property (st_ff == S_DONE && at_end && qctl_ff[`QSC_QC_WRAPAROUND_ENABLE]);
  finish_c: cover property ($rose(fin_ff));
  fault_c: cover property ($rose(mode_fault_flag_ff));
  slave_c: cover property (st_ff == S_DONE && !master);
endmodule : qsc_top
`default_nettype wire

// ==== verification/qsc_peer.sv ====
// qsc_peer: behavioural serial peripheral on the far side of the port
// assumes: bench resolves wire levels; select line has a pull-up
`timescale 1ns/1ns
`default_nettype none
module qsc_peer (
  input wire logic sck,
  input wire logic cs_b,
  input wire logic mosi,
  input wire logic clock_edge_phase,
  output logic miso,
  output logic [15:0] rx,
  output logic [4:0] nbit
);
  logic [15:0] sr;
  logic lead;
  // load reply word when selected
  always @(negedge cs_b) begin
    sr = 16'h9c35;
    rx = 16'h0000;
    nbit = 5'h00;
    lead = 1'b1;
  end
  // sample on one edge, change on the other
  always @(sck) begin
    if (!cs_b) begin
      if (lead ^ clock_edge_phase) begin
        rx = {rx[14:0], mosi};
        nbit = nbit + 5'h01;
      end else if (nbit != 5'h00) begin
        sr = {sr[14:0], 1'b0};
      end
      lead = !lead;
    end
  end
  // released line floats to the pull-up
  assign miso = cs_b ? 1'b1 : sr[15];
endmodule : qsc_peer
`default_nettype wire

// ==== verification/queued_spi_control_test.sv ====
// queued_spi_control_test: register-driven checks of the queued serial port
// assumes: pins have pull-ups; peer model sits on select 0
`timescale 1ns/1ns
`default_nettype none
`include "qsc_consts.svh"
module queued_spi_control_test;
  import qsc_pkg::*;
  logic clock, rst_b, reg_wr, reg_rd, sck_o, sck_oe_b, mosi_o, mosi_oe_b, miso_o, miso_oe_b;
  logic ss_o, ss_oe_b, irq_req, miso_p, ss_ext, clock_edge_phase, idle, sck_w, mosi_w, cs_w, miso_w, ss_w;
  logic [2:0] pcs_o, pcs_oe_b;
  logic [4:0] nbit;
  qsc_addr_t reg_addr;
  qsc_data_t reg_wdata, reg_rdata, rx, d;
  int fails, total_checks, edges;
  // ----------------------------------------
  // pin wires and instances
  // ----------------------------------------
  assign sck_w = sck_oe_b ? 1'b1 : sck_o;
  assign mosi_w = mosi_oe_b ? 1'b1 : mosi_o;
  assign cs_w = ss_oe_b ? 1'b1 : ss_o;
  assign miso_w = miso_oe_b ? miso_p : miso_o;
  assign ss_w = ss_ext & cs_w;
  qsc_top qsc_top_i (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_b(sck_oe_b), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_b(mosi_oe_b), .miso_i(miso_w),
    .miso_o(miso_o), .miso_oe_b(miso_oe_b), .ss_pcs0_b_i(ss_w), .ss_pcs0_b_o(ss_o),
    .ss_pcs0_b_oe_b(ss_oe_b), .pcs_o(pcs_o), .pcs_oe_b(pcs_oe_b), .irq_req(irq_req));
  qsc_peer qsc_peer_i (.sck(sck_w), .cs_b(cs_w), .mosi(mosi_w), .clock_edge_phase(clock_edge_phase), .miso(miso_p),
    .rx(rx), .nbit(nbit));
  // clock, edge count and idle level at select
  always #50 clock = ~clock;
  always @(sck_w) if (!cs_w) edges++;
  always @(negedge cs_w) idle = sck_w;
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input qsc_addr_t a, input qsc_data_t v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input qsc_addr_t a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask : rd
  task automatic chk(input qsc_data_t s, input qsc_data_t e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // one master transfer of entry 0, wait for finish
  task automatic run(input logic [3:0] c, input logic le, input logic lp, input logic [1:0] pm, input int n);
    int k;
    wr(`QSC_A_MCTL, {2'b10, c, pm, 8'h04});
    wr(`QSC_A_TSTAT, {5'h00, lp, 2'b00, 3'b111, 5'h00});
    wr(8'h10, {11'h000, le, 4'he});
    wr(8'h20, 16'ha53c);
    wr(`QSC_A_QCTL, 16'h8000);
    clock_edge_phase = pm[0];
    edges = 0;
    wr(`QSC_A_PCTL, 16'h807e);
    for (k = 0; k < 2000 && irq_req !== 1'b1; k++) @(posedge clock);
    chk(16'(edges), 16'(2 * n));
    chk(16'(nbit), 16'(n));
    chk({15'h0000, idle}, {15'h0000, pm[1]});
    if (n == 16) chk(rx, 16'ha53c);
    rd(8'h20);
    chk(d, lp ? 16'ha53c : 16'h9c35 >> (16 - n));
    rd(`QSC_A_TSTAT);
    chk(d & 16'h00e0, 16'h0080);
    wr(`QSC_A_TSTAT, 16'h00e0);
    repeat (2) @(posedge clock);
    chk({15'h0000, irq_req}, 16'h0000);
  endtask : run
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    ss_ext = 1'b1;
    clock_edge_phase = 1'b1;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(`QSC_A_MCTL);
    chk(d, `QSC_MCTL_RST);
    rd(`QSC_A_QCTL);
    chk(d, 16'h0000);
    rd(8'h7f);
    chk(d, 16'h0000);
    run(4'h0, 1'b1, 1'b0, 2'b01, 16);
    run(4'h3, 1'b1, 1'b0, 2'b00, 8);
    run(4'hc, 1'b1, 1'b0, 2'b11, 12);
    run(4'hc, 1'b0, 1'b0, 2'b10, 8);
    run(4'h0, 1'b1, 1'b1, 2'b01, 16);
    // select pulled low while master
    wr(`QSC_A_QCTL, 16'h0000);
    wr(`QSC_A_TSTAT, 16'h02e0);
    ss_ext <= 1'b0;
    wr(`QSC_A_PCTL, 16'h8076);
    repeat (8) @(posedge clock);
    chk({15'h0000, irq_req}, 16'h0001);
    rd(`QSC_A_TSTAT);
    chk(d & 16'h0040, 16'h0040);
    rd(`QSC_A_MCTL);
    chk(d & 16'h8000, 16'h8000);
    ss_ext <= 1'b1;
    close_out();
  end
  initial begin
    #2000000;
    fails++;
    close_out();
  end
endmodule : queued_spi_control_test
`default_nettype wire
